// >>> bench/tsr_host_sink.sv
// host model: the line it sees on the serial pin
// assumes oe high while the device drives
`timescale 1ns/10ps
module tsr_host_sink (
  input wire logic sys_clk_in,
  input wire logic sdata_out,
  input wire logic sdata_oe_out,
  output logic pin_level_out
);
  logic last_reg = 1'b0;
  // a released line toggles, never keeps a value
  assign pin_level_out = sdata_oe_out ? sdata_out : ~last_reg;
  always_ff @(posedge sys_clk_in)
    last_reg <= pin_level_out;
endmodule

// >>> bench/tsr_slot_routing_assertions.sv
// checker: slot routing pins and readback
// bound to tsr_slot_routing
`timescale 1ns/10ps
module tsr_slot_routing_assertions (
  input wire logic sys_clk_in, sys_rst_in, reg_wr_in, reg_rvalid_out,
  input wire logic bit_strobe_in, sdata_out, sdata_oe_out, slot_clash_out,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire logic [3:0] slot_index_in,
  input wire logic [1:0] ch_bit_in
);
  logic [7:0] c3_reg, c4_reg;
  wire h3 = c3_reg[0] && c3_reg[7:4] == slot_index_in;
  wire h4 = c4_reg[0] && c4_reg[7:4] == slot_index_in;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // shadow copies of the routing registers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || reg_wr_in && reg_addr_in == 8'h0C)
      c3_reg <= sys_rst_in ? 8'h31 : reg_wdata_in & 8'hF1;
    if (sys_rst_in || reg_wr_in && reg_addr_in == 8'h0D)
      c4_reg <= sys_rst_in ? 8'h41 : reg_wdata_in & 8'hF1;
  end
  sequence s_own3;
    bit_strobe_in && h3;
  endsequence
  property p_ch3;
    s_own3 |=> sdata_oe_out && sdata_out == $past(ch_bit_in[0]);
  endproperty
  a_ch3: assert property (p_ch3) else $error("ch3 slot");
  property p_ch4;
    bit_strobe_in && h4 && !h3 |=>
      sdata_oe_out && sdata_out == $past(ch_bit_in[1]);
  endproperty
  a_ch4: assert property (p_ch4) else $error("ch4 slot");
  property p_float;
    bit_strobe_in && !h3 && !h4 |=> !sdata_oe_out && !sdata_out;
  endproperty
  a_float: assert property (p_float) else $error("float");
  property p_hold;
    !bit_strobe_in |=> $stable(sdata_oe_out);
  endproperty
  a_hold: assert property (p_hold) else $error("oe moved");
  property p_resv;
    reg_rvalid_out |-> reg_rdata_out[3:1] == 3'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved");
  sequence s_own4;
    bit_strobe_in && h4;
  endsequence
  property p_clash;
    s_own3 ##0 s_own4 |=> slot_clash_out;
  endproperty
  a_clash: assert property (p_clash) else $error("clash");
  property p_noclash;
    bit_strobe_in && !(h3 && h4) |=> !slot_clash_out;
  endproperty
  a_noclash: assert property (p_noclash) else $error("no clash");
endmodule
bind tsr_slot_routing tsr_slot_routing_assertions chk_u (.*);

// >>> bench/tsr_slot_routing_bench.sv
// bench: random register writes and slot strobes
// assumes the host model on the serial pin
`timescale 1ns/10ps
module tsr_slot_routing_bench;
  logic sys_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic bit_strobe_in = 0, reg_rvalid_out, sdata_out, sdata_oe_out;
  logic slot_clash_out, pin;
  logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, m3, m4;
  logic [3:0] slot_index_in = 0;
  logic [1:0] ch_bit_in = 0;
  logic [31:0] rs = 31, x;
  int n_fail = 0, cmp_count = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  tsr_slot_routing dut_u (.*);
  tsr_host_sink host_u (.sys_clk_in, .sdata_out, .sdata_oe_out,
    .pin_level_out(pin));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [1:0] pin_exp(logic [3:0] s, logic [1:0] b);
    if (m3[0] && m3[7:4] == s) return {1'b1, b[0]};
    if (m4[0] && m4[7:4] == s) return {1'b1, b[1]};
    return 2'b00;
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] e);
    cmp_count++;
    if (seen !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic rw(logic w, logic [7:0] a, logic [7:0] d, logic [7:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    @(posedge sys_clk_in);
    reg_wr_in <= 0;
    reg_rd_in <= 1;
    @(posedge sys_clk_in);
    reg_rd_in <= 0;
    #1 chk("rdata", reg_rdata_out, e);
    chk("rvalid", 8'(reg_rvalid_out), 8'h01);
  endtask
  task automatic send(logic [3:0] s, logic [1:0] b);
    logic o3, o4;
    @(posedge sys_clk_in);
    slot_index_in <= s;
    ch_bit_in <= b;
    bit_strobe_in <= 1;
    @(posedge sys_clk_in);
    bit_strobe_in <= 0;
    #1 chk("oe_data", 8'({sdata_oe_out, sdata_out}), 8'(pin_exp(s, b)));
    o3 = m3[0] && m3[7:4] == s;
    o4 = m4[0] && m4[7:4] == s;
    chk("clash", 8'(slot_clash_out), 8'(o3 && o4));
    if (sdata_oe_out === 1'b1) chk("pin", 8'(pin), 8'(b[!o3]));
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence: reset values, corners, then random traffic
  initial begin
    m3 = 8'h31;
    m4 = 8'h41;
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 0;
    rw(0, 8'h0C, 8'h00, 8'h31);
    rw(0, 8'h0D, 8'h00, 8'h41);
    rw(1, 8'h0E, 8'hFF, 8'h00);
    for (int i = 0; i < 16; i++) send(i[3:0], 2'b10);
    m3 = 8'h40;
    rw(1, 8'h0C, 8'h4E, 8'h40);
    send(4'h4, 2'b01);
    // both channels on slot 4: channel 3 keeps it, clash raised
    m3 = 8'h41;
    rw(1, 8'h0C, 8'h4F, 8'h41);
    send(4'h4, 2'b10);
    for (int i = 0; i < 300; i++) begin
      rs = xs(rs);
      x = rs;
      if (x[8]) m4 = x[7:0] & 8'hF1;
      else m3 = x[7:0] & 8'hF1;
      rw(1, 8'h0C + 8'(x[8]), x[7:0], x[7:0] & 8'hF1);
      send(x[12:9], x[14:13]);
      send(x[19:16], x[21:20]);
    end
    // mid-run reset brings back the reset values
    @(posedge sys_clk_in);
    sys_rst_in <= 1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 0;
    m3 = 8'h31;
    m4 = 8'h41;
    #1 chk("rst_oe", 8'(sdata_oe_out), 8'h00);
    chk("rst_data", 8'(sdata_out), 8'h00);
    chk("rst_clash", 8'(slot_clash_out), 8'h00);
    chk("rst_rvalid", 8'(reg_rvalid_out), 8'h00);
    rw(0, 8'h0C, 8'h00, 8'h31);
    rw(0, 8'h0D, 8'h00, 8'h41);
    send(4'h3, 2'b01);
    send(4'h4, 2'b10);
    tally_and_finish();
  end
  // watchdog: about 2200 cycles expected, allow 10000
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
endmodule

// >>> hw/tsr_chan_route.sv
// tsr_chan_route: one channel's routing register and slot match
// assumes write strobe, address and data are synchronous to sys_clk_in
`timescale 1ns/10ps
module tsr_chan_route
  import tsr_pkg::*;
#(
  parameter logic [7:0] OFS = 8'h0C,
  parameter logic [7:0] RST = 8'h31
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  // frame position
  input wire logic [SLOT_W-1:0] slot_index_in,
  // configuration and match
  output logic [DATA_W-1:0] route_value_out,
  output logic addr_hit_out,
  output logic slot_hit_out,
  output logic drive_out
);
  logic [DATA_W-1:0] route_reg;
  logic [DATA_W-1:0] route_next;
  logic wr_hit;

  // address decode and masked write
  assign addr_hit_out = (reg_addr_in == OFS);
  assign wr_hit = reg_wr_in & addr_hit_out;
  assign route_next = wr_hit ? (reg_wdata_in & WRITABLE_MASK) : route_reg;

  // routing register, reserved bits kept at zero
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      route_reg <= RST;
    end else begin
      route_reg <= route_next;
    end
  end

  // slot match and drive select
  assign route_value_out = route_reg;
  assign slot_hit_out = (route_reg[SLOT_MSB:SLOT_LSB] == slot_index_in);
  assign drive_out = route_reg[DRIVE_BIT];
endmodule

// >>> hw/tsr_pkg.sv
// tsr_pkg: constants shared by the slot routing block
// assumes an 8-bit register port and a 16-slot frame
package tsr_pkg;
  // register port and slot widths, channel count
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SLOT_W = 4;
  localparam int NUM_CH = 2;

  // register offsets
  localparam logic [7:0] CH3_ROUTE_OFS = 8'h0C;
  localparam logic [7:0] CH4_ROUTE_OFS = 8'h0D;

  // field layout of a routing register
  localparam int SLOT_MSB = 7;
  localparam int SLOT_LSB = 4;
  localparam int DRIVE_BIT = 0;
  localparam logic [7:0] WRITABLE_MASK = 8'hF1;

  // reset values
  localparam logic [7:0] CH3_ROUTE_RST = 8'h31;
  localparam logic [7:0] CH4_ROUTE_RST = 8'h41;

  // answer for an unmapped address
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // offsets and resets, indexed by channel position
  localparam logic [7:0] ROUTE_OFS [NUM_CH] = '{CH3_ROUTE_OFS, CH4_ROUTE_OFS};
  localparam logic [7:0] ROUTE_RST [NUM_CH] = '{CH3_ROUTE_RST, CH4_ROUTE_RST};

  // bus activity of the register port
  typedef enum logic [1:0] {
    TSR_IDLE,
    TSR_WRITE,
    TSR_READ
  } tsr_access_type;
endpackage

// >>> hw/tsr_slot_routing.sv
// tsr_slot_routing: slot routing and drive enable for output channels 3, 4
// assumes frame timing supplies the current slot number and bit strobe
// assumes reads and writes arrive as one-cycle strobes
// the pin is driven only while sdata_oe_out is high
// on a clash the lower channel keeps the slot
//
// Overview of operation
// - channel 3 sample goes in selected slot
// - channel 3 drive bit: drive or float
// - channel 4 sample goes in selected slot
// - channel 4 drive bit: drive or float
`timescale 1ns/10ps
module tsr_slot_routing
  import tsr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // frame timing
  input wire logic [SLOT_W-1:0] slot_index_in,
  input wire logic bit_strobe_in,
  // channel sample bits, index 0 is channel 3, index 1 is channel 4
  input wire logic [NUM_CH-1:0] ch_bit_in,
  // serial output pin
  output logic sdata_out,
  output logic sdata_oe_out,
  // status
  output logic slot_clash_out
);
  // per-channel configuration
  logic [DATA_W-1:0] route_value [NUM_CH];
  logic [NUM_CH-1:0] addr_hit;
  logic [NUM_CH-1:0] slot_hit;
  logic [NUM_CH-1:0] drive;
  logic [NUM_CH-1:0] owns_slot;

  // priority among slot owners, lower index first
  logic [NUM_CH-1:0] claimed_below;
  logic [NUM_CH-1:0] wins_slot;
  logic [NUM_CH-1:0] won_bit;

  // read-back terms, one per channel
  logic [DATA_W-1:0] rd_term [NUM_CH];
  logic [DATA_W-1:0] rd_or [NUM_CH+1];

  // decoded access and selections
  tsr_access_type access;
  logic take_rd;
  logic any_hit;
  logic [DATA_W-1:0] rd_mux;
  logic out_bit;
  logic out_en;
  logic clash;

  // output flip-flops
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic sdata_reg;
  logic sdata_next;
  logic oe_reg;
  logic oe_next;
  logic clash_reg;
  logic clash_next;

  // one routing register and slot comparator per channel
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tsr_chan_route #(
        .OFS(ROUTE_OFS[g]),
        .RST(ROUTE_RST[g])
      ) u_route (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in),
        .slot_index_in(slot_index_in),
        .route_value_out(route_value[g]),
        .addr_hit_out(addr_hit[g]),
        .slot_hit_out(slot_hit[g]),
        .drive_out(drive[g])
      );
      // channel drives only its own slot with drive bit set
      assign owns_slot[g] = slot_hit[g] & drive[g];
      // earlier channels keep the slot on a clash
      if (g == 0) begin : g_first
        assign claimed_below[g] = 1'b0;
      end else begin : g_later
        assign claimed_below[g] = claimed_below[g-1] | owns_slot[g-1];
      end
      assign wins_slot[g] = owns_slot[g] & ~claimed_below[g];
      assign won_bit[g] = wins_slot[g] & ch_bit_in[g];
      // read-back term, zero unless this register is addressed
      assign rd_term[g] = addr_hit[g] ? route_value[g] : 8'h00;
      assign rd_or[g+1] = rd_or[g] | rd_term[g];
    end
  endgenerate

  // write has priority over read in the same cycle
  assign access = reg_wr_in ? TSR_WRITE :
                  reg_rd_in ? TSR_READ : TSR_IDLE;
  assign take_rd = (access == TSR_READ);

  // read-back mux, unmapped address answers zero
  assign rd_or[0] = 8'h00;
  assign any_hit = |addr_hit;
  assign rd_mux = any_hit ? rd_or[NUM_CH] : UNMAPPED_READ;

  // slot data from the winning owner, enable from any owner
  assign out_bit = |won_bit;
  assign out_en = |owns_slot;
  assign clash = |(owns_slot & claimed_below);

  // next values of the serial pin and clash flag, sampled on the bit strobe; read data on a taken read
  assign sdata_next = bit_strobe_in ? (out_en & out_bit) : sdata_reg;
  assign oe_next = bit_strobe_in ? out_en : oe_reg;
  assign clash_next = bit_strobe_in ? clash : clash_reg;
  assign rdata_next = take_rd ? rd_mux : rdata_reg;

  // read data, holds the last value read
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // read valid, one cycle after a taken read
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= take_rd;
    end
  end

  // serial data bit, low while floating
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sdata_reg <= 1'b0;
    end else begin
      sdata_reg <= sdata_next;
    end
  end

  // pin enable, loaded on the bit strobe: high when a channel owns the strobed slot
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // clash flag, follows the strobed slot
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clash_reg <= 1'b0;
    end else begin
      clash_reg <= clash_next;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign sdata_out = sdata_reg;
  assign sdata_oe_out = oe_reg;
  assign slot_clash_out = clash_reg;
endmodule
